// ---- hdl/rsl_cfg.svh ----
// constants for the reset status and low supply detect block
`ifndef RSL_CFG_SVH
`define RSL_CFG_SVH
`define RSL_ADDR_STATUS      4'h0
`define RSL_ADDR_CTRL        4'h1
`define RSL_ADDR_IRQ_STAT    4'h2
`define RSL_ADDR_IRQ_MASK    4'h3
`define RSL_ADDR_WDT_CTRL    4'h0
`define RSL_BIT_POR          7
`define RSL_BIT_EXT          6
`define RSL_BIT_SMR          5
`define RSL_BIT_WDT          4
`define RSL_BIT_LOWV         0
`define RSL_CTRL_BOD_EN      0
`define RSL_CTRL_XTAL_EN     1
`define RSL_CTRL_SMALL_PKG   2
`define RSL_CTRL_RESET       8'h05
`define RSL_STATUS_RESET     8'h80
`define RSL_WDT_RESET        8'h00
`define RSL_FILT_MIN_NS      100
`define RSL_FILT_CYCLES      ((`RSL_FILT_MIN_NS + 3) / 4)
`define RSL_IRQ_LOWV         0
`define RSL_IRQ_RESET        1
`endif

// ---- hdl/rsl_pkg.sv ----
// types for the reset status and low supply detect block
package rsl_pkg;
    typedef enum logic [1:0] {
        RSL_BUS_IDLE,
        RSL_BUS_ACK
    } rsl_bus_state_t;
endpackage : rsl_pkg

// ---- hdl/rsl_top.sv ----
// reset status, low supply detect and crystal pin override logic
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`include "rsl_cfg.svh"

// Summary of operation
// R1: in stop state a low external reset pin causes a full system reset.
// R2: low pulses on the reset pin shorter than the minimum width are ignored.
// R3: a low supply raises an interrupt only when that source is enabled.
// R4: low supply detection exists only on the smallest package variant.
// R5: the low supply flag reads one while the supply is below threshold.
// R6: the flag stays one only while the condition persists, then returns to zero.
// R7: software reads never change the low supply flag; of writes, only a control write changing bod_en or small_pkg does.
// R8: the flag is unlatched; transients are caught only by the interrupt path.
// R9: disabling the brownout detector also forces the low supply flag and interrupt off.
// R10: the status register is read-only and reports reset source, stop recovery and watchdog time-out.
// R11: a status read clears its upper four bits after returning them.
// R12: status shares its address with the write-only watchdog control register.
// R13: an enabled crystal oscillator overrides and disables both crystal pins' gpio use.
// R14: upper status flags are set by hardware events and cleared only by a status read.
module rsl_top (
    input  wire logic        clk,               // 250 MHz system clock
    input  wire logic        srst,              // synchronous reset, active high
    input  wire logic [3:0]  avs_address,       // word address
    input  wire logic        avs_read,          // read request
    input  wire logic        avs_write,         // write request
    input  wire logic [31:0] avs_writedata,     // write data
    output logic      [31:0] avs_readdata,      // read data
    output logic             avs_waitrequest,   // stall
    input  wire logic        ext_reset_n,       // external reset pin, active low
    input  wire logic        stop_state,        // device is in stop state
    input  wire logic        supply_low,        // raw detector: supply below threshold
    input  wire logic        por_event,         // power-on reset seen
    input  wire logic        smr_event,         // stop-mode recovery event
    input  wire logic        wdt_timeout,       // watchdog time-out pulse
    input  wire logic [1:0]  gpio_out_in,       // gpio output values of the crystal pins
    input  wire logic [1:0]  gpio_oe_in,        // gpio output enables of the crystal pins
    output logic             sys_reset_req,     // full system reset request
    output logic             irq,               // level interrupt
    output logic             low_supply_flag,   // live low supply indication
    output logic [1:0]       crystal_pin_o,     // drive value for crystal pins
    output logic [1:0]       crystal_pin_oe,    // drive enable for crystal pins
    output logic             xtal_enabled,      // crystal oscillator enable
    output logic [7:0]       wdt_ctrl           // last watchdog control write
);
    // counter wide enough to hold the full filter count
    localparam int FILT_W = $clog2(`RSL_FILT_CYCLES + 1);

    // handshake state and register storage
    rsl_pkg::rsl_bus_state_t bus_state_reg;
    rsl_pkg::rsl_bus_state_t bus_state_next;
    logic [7:0]              ctrl_reg;
    logic [3:0]              src_reg;
    logic [1:0]              irq_stat_reg;
    logic [1:0]              irq_mask_reg;
    logic [FILT_W-1:0]       filt_cnt_reg;
    logic                    rst_pulse_reg;

    // next values of the per-bit flags and pins
    wire  [3:0]              src_next;
    wire  [1:0]              irq_stat_next;
    wire  [1:0]              pin_o_next;
    wire  [1:0]              pin_oe_next;

    // address decodes of the request on the bus
    wire bus_req   = avs_read || avs_write;
    wire bus_take  = bus_state_reg == rsl_pkg::RSL_BUS_IDLE && bus_req;
    wire acc       = bus_state_reg == rsl_pkg::RSL_BUS_ACK;
    wire at_status = avs_address == `RSL_ADDR_STATUS;
    wire at_wdt    = avs_address == `RSL_ADDR_WDT_CTRL;
    wire at_ctrl   = avs_address == `RSL_ADDR_CTRL;
    wire at_istat  = avs_address == `RSL_ADDR_IRQ_STAT;
    wire at_imask  = avs_address == `RSL_ADDR_IRQ_MASK;

    // accesses act only in the answer cycle, so each request acts once
    wire rd_status = acc && avs_read && at_status;                       // R11
    wire wr_wdt    = acc && avs_write && at_wdt;                         // R12
    wire wr_ctrl   = acc && avs_write && at_ctrl;
    wire wr_istat  = acc && avs_write && at_istat;
    wire wr_imask  = acc && avs_write && at_imask;

    // control fields
    wire bod_en    = ctrl_reg[`RSL_CTRL_BOD_EN];
    wire xtal_en   = ctrl_reg[`RSL_CTRL_XTAL_EN];
    wire small_pkg = ctrl_reg[`RSL_CTRL_SMALL_PKG];

    // detector exists on the small package only and shares the brownout circuit
    wire lowv_en   = bod_en && small_pkg;                                // R4 R9
    wire lowv_live = supply_low && lowv_en;                              // R5 R8

    // glitch filter: a pulse once the pin has been low for the full count
    wire ext_low        = !ext_reset_n && stop_state;                    // R1
    wire filt_done      = filt_cnt_reg == FILT_W'(`RSL_FILT_CYCLES);     // R2
    wire filt_last      = filt_cnt_reg == FILT_W'(`RSL_FILT_CYCLES - 1);
    wire rst_pulse_next = ext_low && filt_last;                          // R1 R2
    wire [FILT_W-1:0] filt_cnt_next = !ext_low  ? '0
                                    : filt_done ? filt_cnt_reg
                                    : filt_cnt_reg + FILT_W'(1);         // R2

    // status byte: sticky sources on top, live flag at the bottom
    wire [3:0] src_event  = {por_event, rst_pulse_reg, smr_event, wdt_timeout};  // R10
    wire [3:0] src_clear  = rd_status ? avs_readdata[7:4] : 4'h0;        // R11
    wire [7:0] status_val = {src_reg, 3'b000, lowv_live};                // R5 R6 R10

    // per source flag; only the bits a read returned are cleared, so an
    // event landing between take and answer is not lost
    generate
        for (genvar i = 0; i < 4; i++) begin : g_src
            assign src_next[i] = (src_reg[i] && !src_clear[i]) || src_event[i];  // R14
        end
    endgenerate

    // interrupt sources, bit 0 low supply and bit 1 filtered reset
    wire [1:0] irq_event   = {rst_pulse_reg, lowv_live};                 // R3
    wire [1:0] istat_clear = wr_istat ? avs_writedata[1:0] : 2'b00;
    wire [1:0] irq_gate    = {1'b1, lowv_en};                            // R9

    // per interrupt bit; an event beats a write-one clear in the same cycle
    generate
        for (genvar j = 0; j < 2; j++) begin : g_istat
            assign irq_stat_next[j] = (irq_stat_reg[j] && !istat_clear[j]) || irq_event[j];  // R8
        end
    endgenerate

    // the mask takes hold one cycle after it is written
    wire irq_next = |(irq_stat_next & irq_mask_reg & irq_gate);          // R3 R9

    // crystal owns both pins while enabled; gpio drive is cut off
    generate
        for (genvar k = 0; k < 2; k++) begin : g_pin
            assign pin_o_next[k]  = xtal_en ? 1'b0 : gpio_out_in[k];     // R13
            assign pin_oe_next[k] = xtal_en ? 1'b0 : gpio_oe_in[k];      // R13
        end
    endgenerate

    // read selection; unmapped addresses read zero
    wire [7:0]  rd_byte    = at_status ? status_val
                           : at_ctrl   ? ctrl_reg
                           : at_istat  ? {6'b000000, irq_stat_reg}
                           : at_imask  ? {6'b000000, irq_mask_reg}
                           : 8'h00;
    wire [31:0] rdata_next = {24'h00_0000, rd_byte};

    // next handshake state: one wait cycle, then one answer cycle;
    // the answer cycle always returns to idle, so requests never overlap
    always_comb begin
        case (bus_state_reg)
            rsl_pkg::RSL_BUS_IDLE: bus_state_next = bus_req ? rsl_pkg::RSL_BUS_ACK : rsl_pkg::RSL_BUS_IDLE;
            default:               bus_state_next = rsl_pkg::RSL_BUS_IDLE;
        endcase
    end

    // handshake state
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_state_reg <= rsl_pkg::RSL_BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // waitrequest drops for the answer cycle only;
    // registered, so every request costs two cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !bus_take;
        end
    end

    // read data captured when the request is taken, so the answer cycle
    // sees no mux delay; it holds until the next answer
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_take) begin
            avs_readdata <= rdata_next;
        end
    end

    // filter count restarts on any high sample, so short pulses never finish;
    // it parks at the full count until the pin goes high, one pulse per episode
    always_ff @(posedge clk) begin
        if (srst) begin
            filt_cnt_reg <= '0;
        end else begin
            filt_cnt_reg <= filt_cnt_next;                               // R2
        end
    end

    // one-cycle pulse at the end of the count
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_pulse_reg <= 1'b0;
        end else begin
            rst_pulse_reg <= rst_pulse_next;                             // R1
        end
    end

    // sticky source flags; srst is the block's own reset
    // and loads the por flag set and the other three clear
    always_ff @(posedge clk) begin
        if (srst) begin
            src_reg <= 4'(`RSL_STATUS_RESET >> 4);
        end else begin
            src_reg <= src_next;                                         // R11 R14
        end
    end

    // control register; reset leaves the detector on and the crystal off
    // so the low supply path works before software touches it
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= `RSL_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= avs_writedata[7:0];
        end
    end

    // watchdog control is write-only and never read back
    always_ff @(posedge clk) begin
        if (srst) begin
            wdt_ctrl <= `RSL_WDT_RESET;
        end else if (wr_wdt) begin
            wdt_ctrl <= avs_writedata[7:0];                              // R12
        end
    end

    // interrupt status, sticky until a write of one
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_reg <= 2'b00;
        end else begin
            irq_stat_reg <= irq_stat_next;                               // R8
        end
    end

    // interrupt mask; a masked bit still records its event,
    // so unmasking shows it at once
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask_reg <= 2'b00;
        end else if (wr_imask) begin
            irq_mask_reg <= avs_writedata[1:0];
        end
    end

    // system reset request, two cycles after the last low sample;
    // one cycle wide, the reset sequencer stretches it
    always_ff @(posedge clk) begin
        if (srst) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= rst_pulse_reg;                              // R1
        end
    end

    // level interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;                                             // R3
        end
    end

    // low supply flag follows the detector one cycle late and never latches;
    // a short dip shows only through the interrupt status
    always_ff @(posedge clk) begin
        if (srst) begin
            low_supply_flag <= 1'b0;
        end else begin
            low_supply_flag <= lowv_live;                                // R6 R7
        end
    end

    // crystal enable as seen by the oscillator;
    // it follows the control bit one cycle late, like the pin drive
    always_ff @(posedge clk) begin
        if (srst) begin
            xtal_enabled <= 1'b0;
        end else begin
            xtal_enabled <= xtal_en;
        end
    end

    // crystal pin drive values
    always_ff @(posedge clk) begin
        if (srst) begin
            crystal_pin_o <= 2'b00;
        end else begin
            crystal_pin_o <= pin_o_next;                                 // R13
        end
    end

    // crystal pin drive enables
    always_ff @(posedge clk) begin
        if (srst) begin
            crystal_pin_oe <= 2'b00;
        end else begin
            crystal_pin_oe <= pin_oe_next;                               // R13
        end
    end
endmodule : rsl_top

// ---- testbench/rsl_top_bench.sv ----
// self-checking bench for the reset status and low supply block
`timescale 1ns/1ns
`include "rsl_cfg.svh"
module rsl_top_bench;
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ext_reset_n = 1'b1, stop_state = 1'b0;
    logic supply_low = 1'b0, por_event = 1'b0, smr_event = 1'b0, wdt_timeout = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0] gpio_out_in = 2'h0, gpio_oe_in = 2'h0, crystal_pin_o, crystal_pin_oe;
    logic [7:0] wdt_ctrl;
    logic avs_waitrequest, sys_reset_req, irq, low_supply_flag, xtal_enabled;
    int miscompares = 0, total_checks = 0, pulses = 0;
    always #2 clk = ~clk;
    // count reset requests seen by the pin filter
    always @(posedge clk) if (sys_reset_req === 1'b1) pulses <= pulses + 1;
    rsl_top u_dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .ext_reset_n, .stop_state, .supply_low, .por_event, .smr_event, .wdt_timeout,
        .gpio_out_in, .gpio_oe_in, .sys_reset_req, .irq, .low_supply_flag, .crystal_pin_o, .crystal_pin_oe,
        .xtal_enabled, .wdt_ctrl);
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            give_verdict();
        end
        @(posedge clk);
    endtask : bus
    task automatic t_regs;
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("status", 32'h0000_0080, q);
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("status clr", 32'h0, q);
        bus(0, `RSL_ADDR_CTRL, 32'h0); chk("ctrl", 32'h0000_0005, q);
        bus(0, 4'h7, 32'h0); chk("unmapped", 32'h0, q);
        bus(1, `RSL_ADDR_WDT_CTRL, 32'h0000_00a5); chk("wdt", 32'h0000_00a5, {24'h0, wdt_ctrl});
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("status ro", 32'h0, q);
        $display("regs done");
    endtask : t_regs
    task automatic t_filter;
        stop_state <= 1'b1;
        ext_reset_n <= 1'b0;
        repeat (22) @(posedge clk);
        ext_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("short low", 32'h0, pulses);
        ext_reset_n <= 1'b0;
        repeat (40) @(posedge clk);
        ext_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("long low", 32'h1, pulses);
        stop_state <= 1'b0;
        $display("filter done");
    endtask : t_filter
    task automatic t_events;
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("ext src", 32'h0000_0040, q);
        por_event <= 1'b1;
        smr_event <= 1'b1;
        wdt_timeout <= 1'b1;
        @(posedge clk);
        por_event <= 1'b0;
        smr_event <= 1'b0;
        wdt_timeout <= 1'b0;
        @(posedge clk);
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("events", 32'h0000_00b0, q);
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("events clr", 32'h0, q);
        $display("events done");
    endtask : t_events
    task automatic t_lowv;
        bus(1, `RSL_ADDR_IRQ_MASK, 32'h1);
        supply_low <= 1'b1;
        repeat (4) @(posedge clk);
        chk("flag", 32'h1, low_supply_flag);
        bus(1, `RSL_ADDR_STATUS, 32'h0);
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("st low", 32'h1, q);
        bus(0, `RSL_ADDR_STATUS, 32'h0); chk("st low2", 32'h1, q);
        chk("irq", 32'h1, irq);
        supply_low <= 1'b0;
        repeat (4) @(posedge clk);
        chk("flag gone", 32'h0, low_supply_flag);
        chk("irq held", 32'h1, irq);
        // register writes reach the outputs one cycle after the answer
        bus(1, `RSL_ADDR_CTRL, 32'h4);
        @(posedge clk);
        chk("bod off held", 32'h0, irq);
        bus(1, `RSL_ADDR_CTRL, 32'h5);
        @(posedge clk);
        chk("bod on again", 32'h1, irq);
        bus(1, `RSL_ADDR_IRQ_MASK, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, irq);
        bus(1, `RSL_ADDR_IRQ_STAT, 32'h1);
        bus(1, `RSL_ADDR_IRQ_MASK, 32'h1);
        @(posedge clk);
        chk("irq clr", 32'h0, irq);
        bus(1, `RSL_ADDR_CTRL, 32'h4);
        supply_low <= 1'b1;
        repeat (4) @(posedge clk);
        chk("bod off flag", 32'h0, low_supply_flag);
        chk("bod off irq", 32'h0, irq);
        bus(1, `RSL_ADDR_CTRL, 32'h1);
        @(posedge clk);
        chk("big pkg", 32'h0, low_supply_flag);
        chk("big pkg irq", 32'h0, irq);
        supply_low <= 1'b0;
        $display("low supply done");
    endtask : t_lowv
    task automatic t_xtal;
        gpio_out_in <= 2'h2;
        gpio_oe_in <= 2'h3;
        bus(1, `RSL_ADDR_CTRL, 32'h5); chk("gpio oe", 32'h3, crystal_pin_oe);
        chk("gpio o", 32'h2, crystal_pin_o);
        bus(1, `RSL_ADDR_CTRL, 32'h7);
        @(posedge clk);
        chk("xtal", 32'h1, xtal_enabled);
        chk("pin oe", 32'h0, crystal_pin_oe);
        chk("pin o", 32'h0, crystal_pin_o);
        $display("crystal done");
    endtask : t_xtal
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_filter();
        t_events();
        t_lowv();
        t_xtal();
        give_verdict();
    end
endmodule : rsl_top_bench

// ---- testbench/rsl_top_monitor.sv ----
// checker for bus timing, reset filter, low supply flag and pin override
`timescale 1ns/1ns
module rsl_top_monitor (
    input wire logic        clk,              // block clock
    input wire logic        srst,             // synchronous reset
    input wire logic        avs_read,         // read request
    input wire logic        avs_write,        // write request
    input wire logic        avs_waitrequest,  // stall
    input wire logic        ext_reset_n,      // reset pin, active low
    input wire logic        stop_state,       // stop state
    input wire logic        supply_low,       // raw detector
    input wire logic        sys_reset_req,    // reset request pulse
    input wire logic        low_supply_flag,  // live flag
    input wire logic        xtal_enabled,     // crystal enable
    input wire logic [3:0]  avs_address,      // word address
    input wire logic [31:0] avs_readdata,     // read data
    input wire logic [1:0]  crystal_pin_o,    // pin drive values
    input wire logic [1:0]  crystal_pin_oe    // pin drive enables
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // bus answers stand one cycle and always have a request behind them
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
    a_ack_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("stray answer");
    a_req_answered: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest) else $error("no answer");
    a_status_gaps:
        assert property (!avs_waitrequest && $past(avs_read && avs_address == 4'h0) |-> avs_readdata[3:1] == 3'h0)
        else $error("status gap bits set");
    a_flag_follows:
        assert property (!$past(supply_low) |-> !low_supply_flag) else $error("flag without low supply");
    // a reset needs a long low episode inside stop state
    a_reset_filtered:
        assert property (sys_reset_req |-> $past(!ext_reset_n && stop_state, 2) && $past(!ext_reset_n, 14)
            && $past(!ext_reset_n, 26)) else $error("reset from short pulse");
    a_reset_pulse:
        assert property (sys_reset_req |=> !sys_reset_req) else $error("reset pulse too long");
    a_xtal_override:
        assert property (xtal_enabled && $past(xtal_enabled) |-> crystal_pin_oe == 2'h0 && crystal_pin_o == 2'h0)
        else $error("crystal pins driven");
endmodule : rsl_top_monitor

bind rsl_top rsl_top_monitor u_mon (.clk, .srst, .avs_read, .avs_write, .avs_waitrequest, .ext_reset_n,
    .stop_state, .supply_low, .sys_reset_req, .low_supply_flag, .xtal_enabled, .avs_address, .avs_readdata,
    .crystal_pin_o, .crystal_pin_oe);
